// >>> design/dbr_pkg.sv
// Constants shared by the DC brake and regen select block.
// Assumes a 250 MHz clock and a 4-bit register address space.
package dbr_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] ADDR_START_FREQ  = 4'h0;
    localparam logic [3:0] ADDR_DURATION    = 4'h1;
    localparam logic [3:0] ADDR_VOLT_PCT    = 4'h2;
    localparam logic [3:0] ADDR_REGEN_SEL   = 4'h3;
    localparam logic [3:0] ADDR_SPEC_DUTY   = 4'h4;
    localparam logic [3:0] ADDR_MOTOR_TYPE  = 4'h5;
    localparam logic [3:0] ADDR_USER_GROUP  = 4'h6;
    localparam logic [3:0] ADDR_STATUS      = 4'h7;
    localparam logic [3:0] ADDR_TERM_BASE   = 4'h8;
    localparam int         TERM_COUNT       = 7;

    // ****************************************
    // Reset values and limits
    // ****************************************
    localparam logic [15:0] START_FREQ_RST  = 16'h012c; // 3.00 Hz in 0.01 Hz
    localparam logic [15:0] START_FREQ_MAX  = 16'h2ee0; // 120.00 Hz
    localparam logic [7:0]  DURATION_RST    = 8'h05;    // 0.5 s in 0.1 s
    localparam logic [7:0]  DURATION_MAX    = 8'h64;    // 10.0 s
    localparam logic [7:0]  VOLT_RST        = 8'h04;
    localparam logic [7:0]  VOLT_MAX        = 8'h1e;    // 30 %
    localparam logic [7:0]  VOLT_STD        = 8'h04;
    localparam logic [7:0]  VOLT_CT         = 8'h02;
    localparam logic [7:0]  DUTY_MAX        = 8'h1e;
    localparam logic [7:0]  DUTY_CLASS_A    = 8'h03;
    localparam logic [7:0]  DUTY_CLASS_B    = 8'h02;
    localparam logic [1:0]  REGEN_MAX       = 2'h2;
    localparam logic [7:0]  TERM_FUNC_ENABLE = 8'h0a;
    localparam logic [7:0]  TERM_FUNC_RST   = 8'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS   = 4;
    localparam int TENTH_SEC_NS    = 100_000_000;
    localparam int TENTH_SEC_CYC   = TENTH_SEC_NS / CLK_PERIOD_NS;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        REGEN_BASIC,
        REGEN_HIGH_DUTY,
        REGEN_HC_RESTART
    } dbr_regen_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_BRAKE,
        ST_STOPPED
    } dbr_state_t;

endpackage

// >>> design/dbr_tmap_if.sv
// Carrier between the brake controller and its terminal function map.
// Assumes both sides run on the same clock.
`timescale 1ns/100ps
interface dbr_tmap_if;
    logic       wr_en;
    logic [2:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       enable_level;
    logic       enable_assigned;

    modport ctrl (
        output wr_en,
        output idx,
        output wdata,
        input  rdata,
        input  enable_level,
        input  enable_assigned
    );
    modport map (
        input  wr_en,
        input  idx,
        input  wdata,
        output rdata,
        output enable_level,
        output enable_assigned
    );
endinterface

// >>> design/dbr_term_map.sv
// Function selection memory of the contact input terminals.
// Assumes terminal levels are synchronous to clock and active high.
`timescale 1ns/100ps
module dbr_term_map #(
    parameter int N = dbr_pkg::TERM_COUNT
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [N-1:0] terminals,
    dbr_tmap_if.map           bus
);
    logic [7:0]   func_q [N];
    logic [7:0]   rdata_q;
    logic [N-1:0] hit;

    // ****************************************
    // Enable routing
    // ****************************************
    // enable follows code 10
    for (genvar i = 0; i < N; i++) begin : g_hit
        assign hit[i] = (func_q[i] == dbr_pkg::TERM_FUNC_ENABLE);
    end
    assign bus.enable_assigned = |hit;
    assign bus.enable_level    = &(terminals | ~hit);
    assign bus.rdata           = rdata_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                func_q[i] <= dbr_pkg::TERM_FUNC_RST;
            end
            rdata_q <= 8'h00;
        end else begin
            if (bus.wr_en && (int'(bus.idx) < N)) begin
                func_q[bus.idx] <= bus.wdata;
            end
            rdata_q <= (int'(bus.idx) < N) ? func_q[bus.idx] : 8'h00;
        end
    end
endmodule

// >>> design/dbr_brake_ctrl.sv
// DC injection brake, regen option selection and operation enable gating.
// Assumes inputs synchronous to clock; frequency in 0.01 Hz, current in any
// common unit shared with rated_current.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps

// How it works
// - Braking starts when decelerating frequency falls to the start frequency.
// - Braking lasts the programmed duration, 0.1 to 10 s.
// - Duration zero disables braking; motor coasts at stop.
// - Brake voltage is a percentage setting from 0 to 30.
// - Voltage zero disables braking; motor coasts at stop.
// - Affected rating, 4 percent, standard to constant-torque code gives 2.
// - Affected rating, 2 percent, constant-torque to standard code gives 4.
// - Brake voltage drops while output current reaches the rated current.
// - Regen select decodes basic, high-duty resistor, or converter with restart.
// - Special regen duty accepts 0 to 30 percent, used for high-duty.
// - Regen select zero ignores special duty; fixed 3 or 2 percent.
// - Operation enable comes from the terminal whose function code is 10.
// - Output shuts off while the operation enable input is inactive.
// - Brake parameters are writable only while user group select is 0.
module dbr_brake_ctrl #(
    parameter int TENTH_CYCLES = dbr_pkg::TENTH_SEC_CYC,
    parameter int N_TERM       = dbr_pkg::TERM_COUNT
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [15:0]            reg_rdata,
    input  wire logic [15:0]       output_freq,
    input  wire logic              decelerating,
    input  wire logic [15:0]       output_current,
    input  wire logic [15:0]       rated_current,
    input  wire logic              affected_rating,
    input  wire logic              model_class_b,
    input  wire logic [N_TERM-1:0] contact_inputs,
    output logic                   dc_brake_active,
    output logic [7:0]             dc_brake_volt,
    output logic                   output_shutoff,
    output logic                   regen_high_duty,
    output logic                   regen_hc_restart,
    output logic [7:0]             regen_duty
);
    localparam int TW = $clog2(TENTH_CYCLES + 1);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic is_standard(input logic [7:0] code);
        case (code)
            8'd0, 8'd3, 8'd4, 8'd5, 8'd6, 8'd23, 8'd24, 8'd40, 8'd43, 8'd44: is_standard = 1'b1;
            default: is_standard = 1'b0;
        endcase
    endfunction

    function automatic logic is_const_torque(input logic [7:0] code);
        case (code)
            8'd1, 8'd13, 8'd14, 8'd15, 8'd16, 8'd50, 8'd53, 8'd54: is_const_torque = 1'b1;
            default: is_const_torque = 1'b0;
        endcase
    endfunction

    // ****************************************
    // Registers and decode
    // ****************************************
    logic [15:0]         start_freq_q;
    logic [7:0]          duration_q;
    logic [7:0]          volt_pct_q;
    logic [1:0]          regen_sel_q;
    logic [7:0]          spec_duty_q;
    logic [7:0]          motor_type_q;
    logic [7:0]          user_group_q;
    logic [15:0]         rdata_q;
    logic                term_rd_q;
    dbr_pkg::dbr_state_t state_q;
    logic [7:0]          tenths_q;
    logic [TW-1:0]       sub_q;
    logic [7:0]          volt_out_q;
    logic                brake_en_d;
    logic                term_sel;
    logic                params_open;
    logic [7:0]          wr_byte;
    logic                wr_start, wr_dur, wr_volt, wr_regen, wr_duty, wr_motor, wr_user;
    logic                type_std_to_ct;
    logic                type_ct_to_std;
    logic                at_start_freq;
    logic                tenth_done;
    logic                brake_done;
    logic                enable_ok;
    logic                over_current;
    logic [15:0]         status_word;

    dbr_tmap_if tmap ();

    dbr_term_map #(
        .N (N_TERM)
    ) u_term_map (
        .clock     (clock),
        .rst       (rst),
        .terminals (contact_inputs),
        .bus       (tmap.map)
    );

    // writes gated by user group select
    assign params_open = (user_group_q == 8'h00);
    assign wr_byte     = reg_wdata[7:0];
    assign term_sel    = (reg_addr >= dbr_pkg::ADDR_TERM_BASE);
    assign wr_start = reg_wr && params_open && (reg_addr == dbr_pkg::ADDR_START_FREQ)
                      && (reg_wdata <= dbr_pkg::START_FREQ_MAX);
    // duration range 0 to 10 s
    assign wr_dur   = reg_wr && params_open && (reg_addr == dbr_pkg::ADDR_DURATION)
                      && (reg_wdata <= {8'h00, dbr_pkg::DURATION_MAX});
    // voltage range 0 to 30 percent
    assign wr_volt  = reg_wr && params_open && (reg_addr == dbr_pkg::ADDR_VOLT_PCT)
                      && (reg_wdata <= {8'h00, dbr_pkg::VOLT_MAX});
    assign wr_regen = reg_wr && params_open && (reg_addr == dbr_pkg::ADDR_REGEN_SEL)
                      && (reg_wdata <= {14'h0000, dbr_pkg::REGEN_MAX});
    // special duty range 0 to 30 percent
    assign wr_duty  = reg_wr && params_open && (reg_addr == dbr_pkg::ADDR_SPEC_DUTY)
                      && (reg_wdata <= {8'h00, dbr_pkg::DUTY_MAX});
    assign wr_motor = reg_wr && params_open && (reg_addr == dbr_pkg::ADDR_MOTOR_TYPE)
                      && (reg_wdata[15:8] == 8'h00);
    // User group select itself stays writable, else the lock could never open
    assign wr_user  = reg_wr && (reg_addr == dbr_pkg::ADDR_USER_GROUP);

    assign tmap.wr_en = reg_wr && params_open && term_sel && (reg_wdata[15:8] == 8'h00);
    assign tmap.idx   = 3'(reg_addr - dbr_pkg::ADDR_TERM_BASE);
    assign tmap.wdata = wr_byte;

    assign type_std_to_ct = wr_motor && affected_rating && is_standard(motor_type_q)
                            && is_const_torque(wr_byte) && (volt_pct_q == dbr_pkg::VOLT_STD);
    assign type_ct_to_std = wr_motor && affected_rating && is_const_torque(motor_type_q)
                            && is_standard(wr_byte) && (volt_pct_q == dbr_pkg::VOLT_CT);

    always_ff @(posedge clock) begin
        if (rst) begin
            start_freq_q <= dbr_pkg::START_FREQ_RST;
            duration_q   <= dbr_pkg::DURATION_RST;
            volt_pct_q   <= dbr_pkg::VOLT_RST;
            regen_sel_q  <= 2'h0;
            spec_duty_q  <= 8'h00;
            motor_type_q <= 8'h00;
            user_group_q <= 8'h00;
        end else begin
            if (wr_start) start_freq_q <= reg_wdata;
            if (wr_dur)   duration_q   <= wr_byte;
            if (wr_regen) regen_sel_q  <= reg_wdata[1:0];
            if (wr_duty)  spec_duty_q  <= wr_byte;
            if (wr_motor) motor_type_q <= wr_byte;
            if (wr_user)  user_group_q <= wr_byte;
            if (type_std_to_ct) begin
                volt_pct_q <= dbr_pkg::VOLT_CT;
            end else if (type_ct_to_std) begin
                volt_pct_q <= dbr_pkg::VOLT_STD;
            end else if (wr_volt) begin
                volt_pct_q <= wr_byte;
            end
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    assign status_word = {10'h000, over_current, enable_ok, output_shutoff,
                          dc_brake_active, 2'(state_q)};

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_q   <= 16'h0000;
            term_rd_q <= 1'b0;
        end else begin
            term_rd_q <= reg_rd && term_sel;
            case (reg_addr)
                dbr_pkg::ADDR_START_FREQ: rdata_q <= start_freq_q;
                dbr_pkg::ADDR_DURATION:   rdata_q <= {8'h00, duration_q};
                dbr_pkg::ADDR_VOLT_PCT:   rdata_q <= {8'h00, volt_pct_q};
                dbr_pkg::ADDR_REGEN_SEL:  rdata_q <= {14'h0000, regen_sel_q};
                dbr_pkg::ADDR_SPEC_DUTY:  rdata_q <= {8'h00, spec_duty_q};
                dbr_pkg::ADDR_MOTOR_TYPE: rdata_q <= {8'h00, motor_type_q};
                dbr_pkg::ADDR_USER_GROUP: rdata_q <= {8'h00, user_group_q};
                dbr_pkg::ADDR_STATUS:     rdata_q <= status_word;
                default:                  rdata_q <= 16'h0000;
            endcase
        end
    end

    // Terminal map answers from its own registered read port
    assign reg_rdata = term_rd_q ? {8'h00, tmap.rdata} : rdata_q;

    // ****************************************
    // Brake sequence
    // ****************************************
    // zero duration means coast
    assign brake_en_d    = (duration_q != 8'h00) && (volt_pct_q != 8'h00);
    assign at_start_freq = decelerating && (output_freq <= start_freq_q);
    assign tenth_done    = (sub_q == TW'(TENTH_CYCLES - 1));
    assign brake_done    = tenth_done && (tenths_q <= 8'h01);
    // Unassigned enable function is treated as always enabled
    assign enable_ok     = !tmap.enable_assigned || tmap.enable_level;

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q  <= dbr_pkg::ST_RUN;
            tenths_q <= 8'h00;
            sub_q    <= '0;
        end else begin
            case (state_q)
                dbr_pkg::ST_RUN: begin
                    sub_q <= '0;
                    if (at_start_freq) begin
                        tenths_q <= duration_q;
                        state_q  <= brake_en_d ? dbr_pkg::ST_BRAKE : dbr_pkg::ST_STOPPED;
                    end
                end
                dbr_pkg::ST_BRAKE: begin
                    // count duration in 0.1 s steps
                    sub_q <= tenth_done ? '0 : sub_q + TW'(1);
                    if (tenth_done) begin
                        tenths_q <= tenths_q - 8'h01;
                    end
                    if (brake_done) begin
                        state_q <= dbr_pkg::ST_STOPPED;
                    end
                end
                dbr_pkg::ST_STOPPED: begin
                    // A new run command leaves the stop
                    if (!decelerating && (output_freq > start_freq_q)) begin
                        state_q <= dbr_pkg::ST_RUN;
                    end
                end
                default: state_q <= dbr_pkg::ST_RUN;
            endcase
        end
    end

    // ****************************************
    // Brake voltage with current limit
    // ****************************************
    assign over_current = (output_current >= rated_current);

    // back off while current at rated
    always_ff @(posedge clock) begin
        if (rst) begin
            volt_out_q <= 8'h00;
        end else if (state_q != dbr_pkg::ST_BRAKE) begin
            volt_out_q <= 8'h00;
        end else if (over_current) begin
            volt_out_q <= (volt_out_q == 8'h00) ? 8'h00 : volt_out_q - 8'h01;
        end else if (volt_out_q < volt_pct_q) begin
            volt_out_q <= volt_out_q + 8'h01;
        end else begin
            volt_out_q <= volt_pct_q;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // enable input gates the output
    assign output_shutoff   = !enable_ok || (state_q == dbr_pkg::ST_STOPPED);
    assign dc_brake_active  = (state_q == dbr_pkg::ST_BRAKE) && enable_ok;
    assign dc_brake_volt    = dc_brake_active ? volt_out_q : 8'h00;

    assign regen_high_duty  = (regen_sel_q == 2'(dbr_pkg::REGEN_HIGH_DUTY));
    assign regen_hc_restart = (regen_sel_q == 2'(dbr_pkg::REGEN_HC_RESTART));
    assign regen_duty = (regen_sel_q == 2'(dbr_pkg::REGEN_BASIC))
                        ? (model_class_b ? dbr_pkg::DUTY_CLASS_B : dbr_pkg::DUTY_CLASS_A)
                        : spec_duty_q;
endmodule

// >>> verif/dbr_conv_model.sv
// Model of the external converter unit whose ready output feeds a terminal.
// Assumes the bench commands a fault to drop the ready output.
`timescale 1ns/100ps
module dbr_conv_model (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic fault_req,
    output logic      common_converter_ready_out
);
    logic ready_q;
    // ready follows health
    // Not ready while in reset, like a unit still charging its bus
    always_ff @(posedge clock) begin
        if (rst) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= !fault_req;
        end
    end
    assign common_converter_ready_out = ready_q;
endmodule

// >>> verif/dbr_brake_ctrl_sva.sv
// Port checker for the DC brake controller.
// Assumes it is bound onto dbr_brake_ctrl with the same parameters.
`timescale 1ns/100ps
module dbr_brake_ctrl_sva #(
    parameter int TENTH_CYCLES = 4,
    parameter int N_TERM       = 7
) (
    input wire logic              clock,
    input wire logic              rst,
    input wire logic [3:0]        reg_addr,
    input wire logic [15:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [15:0]       reg_rdata,
    input wire logic [15:0]       output_freq,
    input wire logic              decelerating,
    input wire logic [15:0]       output_current,
    input wire logic [15:0]       rated_current,
    input wire logic              affected_rating,
    input wire logic              model_class_b,
    input wire logic [N_TERM-1:0] contact_inputs,
    input wire logic              dc_brake_active,
    input wire logic [7:0]        dc_brake_volt,
    input wire logic              output_shutoff,
    input wire logic              regen_high_duty,
    input wire logic              regen_hc_restart,
    input wire logic [7:0]        regen_duty
);
    localparam int MAX_BRK = 100 * TENTH_CYCLES;
    int unsigned brk_cnt_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Longest brake is ten seconds of tenths
    always_ff @(posedge clock) begin
        if (rst || !dc_brake_active) begin
            brk_cnt_q <= 0;
        end else begin
            brk_cnt_q <= brk_cnt_q + 1;
        end
    end
    a_reset_quiet: assert property ($fell(rst) |-> !dc_brake_active && dc_brake_volt == 8'h00 && !output_shutoff)
        else $error("outputs not quiet after reset");
    a_brake_bounded: assert property (brk_cnt_q <= MAX_BRK)
        else $error("brake lasted too long");
    a_volt_limit: assert property (dc_brake_volt <= 8'h1e)
        else $error("brake volt above limit");
    a_volt_step: assert property (dc_brake_active && $past(dc_brake_active) |->
        dc_brake_volt == $past(dc_brake_volt) || dc_brake_volt == $past(dc_brake_volt) + 8'h01
        || dc_brake_volt + 8'h01 == $past(dc_brake_volt)) else $error("brake volt jumped");
    a_oc_step_down: assert property (dc_brake_active && output_current >= rated_current
        && dc_brake_volt != 8'h00 ##1 dc_brake_active |-> dc_brake_volt < $past(dc_brake_volt))
        else $error("brake volt not reduced at rated current");
    a_shutoff_gate: assert property (output_shutoff |-> !dc_brake_active)
        else $error("brake active while output shut off");
    a_idle_volt: assert property (!dc_brake_active && !output_shutoff |-> dc_brake_volt == 8'h00)
        else $error("brake volt outside braking");
    a_regen_onehot: assert property (!(regen_high_duty && regen_hc_restart))
        else $error("two regen options at once");
    a_fixed_duty: assert property (!regen_high_duty && !regen_hc_restart |->
        regen_duty == (model_class_b ? 8'h02 : 8'h03)) else $error("fixed regen duty wrong");
    c_brake: cover property ($rose(dc_brake_active));
    c_oc: cover property (dc_brake_active && output_current >= rated_current);
    c_high_duty: cover property (regen_high_duty);
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the DC brake and regen select controller.
// Assumes 250 MHz clock, a brake tenth of 4 cycles, converter on terminal 3.
`timescale 1ns/100ps
module testbench;
    localparam int TENTH = 4;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] output_freq = 16'h0fa0;
    logic        decelerating = 1'b0;
    logic [15:0] output_current = 16'h0010;
    logic        affected_rating = 1'b0;
    logic        model_class_b = 1'b0;
    logic [6:0]  tb_inputs = 7'h45;
    logic        conv_fault = 1'b0;
    logic        ready;
    logic        active, shutoff, high_duty, hc_restart;
    logic [7:0]  volt, duty;
    int          n_errors = 0, num_checks = 0;
    wire  [6:0]  contact_inputs = {tb_inputs[6:4], ready, tb_inputs[2:0]};
    always #2 clock = ~clock;
    dbr_conv_model dbr_conv_model_i (.clock(clock), .rst(rst), .fault_req(conv_fault),
        .common_converter_ready_out(ready));
    dbr_brake_ctrl #(.TENTH_CYCLES(TENTH)) dbr_brake_ctrl_i (.clock(clock), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .output_freq(output_freq), .decelerating(decelerating),
        .output_current(output_current), .rated_current(16'h0100),
        .affected_rating(affected_rating), .model_class_b(model_class_b),
        .contact_inputs(contact_inputs), .dc_brake_active(active), .dc_brake_volt(volt),
        .output_shutoff(shutoff), .regen_high_duty(high_duty),
        .regen_hc_restart(hc_restart), .regen_duty(duty));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("register %h", a), exp, reg_rdata);
    endtask
    // Decelerate through start frequency, measure brake, recover
    task automatic brake_run(input logic oc, output int n, output logic [7:0] vmax,
                             output logic [7:0] vlast);
        n = 0;
        vmax = 8'h00;
        vlast = 8'h00;
        @(posedge clock);
        decelerating <= 1'b1;
        output_freq <= 16'h012d;
        tick(2);
        chk("active above start", 16'h0000, {15'h0, active});
        @(posedge clock);
        output_freq <= 16'h012c;
        tick(1);
        while (active === 1'b1 && n < 100) begin
            n++;
            vlast = volt;
            if (vlast > vmax) vmax = vlast;
            if (oc && n == 9) output_current <= 16'hffff;
            tick(1);
        end
        output_current <= 16'h0010;
        if (n >= 100) begin
            n_errors++;
            report_and_stop();
        end
        rd(dbr_pkg::ADDR_STATUS, 16'h001a);
        @(posedge clock);
        decelerating <= 1'b0;
        output_freq <= 16'h0fa0;
        tick(2);
    endtask
    task automatic t_reset_values();
        rd(dbr_pkg::ADDR_START_FREQ, 16'h012c);
        rd(dbr_pkg::ADDR_DURATION, 16'h0005);
        rd(dbr_pkg::ADDR_VOLT_PCT, 16'h0004);
        rd(dbr_pkg::ADDR_REGEN_SEL, 16'h0000);
        rd(dbr_pkg::ADDR_SPEC_DUTY, 16'h0000);
        rd(4'hf, 16'h0000);
        $display("test reset_values done");
    endtask
    task automatic t_brake();
        int         n;
        logic [7:0] vmax, vlast;
        wr(dbr_pkg::ADDR_DURATION, 16'h0002);
        wr(dbr_pkg::ADDR_VOLT_PCT, 16'h0005);
        brake_run(1'b0, n, vmax, vlast);
        chk("brake cycles", 16'(2 * TENTH), 16'(n));
        chk("brake volt", 16'h0005, {8'h00, vmax});
        wr(dbr_pkg::ADDR_DURATION, 16'h0003);
        wr(dbr_pkg::ADDR_VOLT_PCT, 16'h0008);
        brake_run(1'b1, n, vmax, vlast);
        chk("peak before limit", 16'h0008, {8'h00, vmax});
        chk("volt after limit", 16'h0001, {15'h0, vlast < vmax});
        for (int i = 0; i < 2; i++) begin
            wr(dbr_pkg::ADDR_DURATION, i == 0 ? 16'h0000 : 16'h0005);
            wr(dbr_pkg::ADDR_VOLT_PCT, i == 0 ? 16'h0005 : 16'h0000);
            brake_run(1'b0, n, vmax, vlast);
            chk("coast cycles", 16'h0000, 16'(n));
        end
        $display("test brake done");
    endtask
    task automatic t_motor_swap();
        wr(dbr_pkg::ADDR_VOLT_PCT, 16'h0004);
        affected_rating <= 1'b1;
        wr(dbr_pkg::ADDR_MOTOR_TYPE, 16'h0036);
        rd(dbr_pkg::ADDR_VOLT_PCT, 16'h0002);
        wr(dbr_pkg::ADDR_MOTOR_TYPE, 16'h002c);
        rd(dbr_pkg::ADDR_VOLT_PCT, 16'h0004);
        affected_rating <= 1'b0;
        wr(dbr_pkg::ADDR_MOTOR_TYPE, 16'h000d);
        rd(dbr_pkg::ADDR_VOLT_PCT, 16'h0004);
        $display("test motor_swap done");
    endtask
    task automatic t_regen();
        wr(dbr_pkg::ADDR_SPEC_DUTY, 16'h0014);
        for (int c = 0; c < 2; c++) begin
            model_class_b <= c[0];
            tick(1);
            chk("fixed duty", c == 0 ? 16'h0003 : 16'h0002, {8'h00, duty});
        end
        wr(dbr_pkg::ADDR_REGEN_SEL, 16'h0001);
        tick(1);
        chk("high duty flags", 16'h0002, {14'h0, high_duty, hc_restart});
        chk("special duty", 16'h0014, {8'h00, duty});
        wr(dbr_pkg::ADDR_REGEN_SEL, 16'h0002);
        tick(1);
        chk("restart flags", 16'h0001, {14'h0, high_duty, hc_restart});
        wr(dbr_pkg::ADDR_REGEN_SEL, 16'h0003);
        rd(dbr_pkg::ADDR_REGEN_SEL, 16'h0002);
        wr(dbr_pkg::ADDR_SPEC_DUTY, 16'h001f);
        rd(dbr_pkg::ADDR_SPEC_DUTY, 16'h0014);
        wr(dbr_pkg::ADDR_REGEN_SEL, 16'h0000);
        $display("test regen done");
    endtask
    task automatic t_enable();
        wr(dbr_pkg::ADDR_TERM_BASE + 4'h3, 16'h000a);
        rd(dbr_pkg::ADDR_TERM_BASE + 4'h3, 16'h000a);
        for (int f = 1; f >= 0; f--) begin
            conv_fault <= f[0];
            tick(3);
            chk("shutoff by enable", 16'(f), {15'h0, shutoff});
        end
        wr(dbr_pkg::ADDR_TERM_BASE + 4'h3, 16'h0000);
        $display("test enable done");
    endtask
    task automatic t_user_group();
        wr(dbr_pkg::ADDR_VOLT_PCT, 16'h0006);
        wr(dbr_pkg::ADDR_USER_GROUP, 16'h0001);
        wr(dbr_pkg::ADDR_VOLT_PCT, 16'h0007);
        rd(dbr_pkg::ADDR_VOLT_PCT, 16'h0006);
        wr(dbr_pkg::ADDR_USER_GROUP, 16'h0000);
        wr(dbr_pkg::ADDR_VOLT_PCT, 16'h001f);
        rd(dbr_pkg::ADDR_VOLT_PCT, 16'h0006);
        wr(dbr_pkg::ADDR_VOLT_PCT, 16'h001e);
        rd(dbr_pkg::ADDR_VOLT_PCT, 16'h001e);
        $display("test user_group done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        t_reset_values();
        t_brake();
        t_motor_swap();
        t_regen();
        t_enable();
        t_user_group();
        report_and_stop();
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge clock);
        n_errors++;
        report_and_stop();
    end
endmodule
bind dbr_brake_ctrl dbr_brake_ctrl_sva #(.TENTH_CYCLES(TENTH_CYCLES), .N_TERM(N_TERM)) sva_i (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .output_freq(output_freq),
    .decelerating(decelerating), .output_current(output_current),
    .rated_current(rated_current), .affected_rating(affected_rating),
    .model_class_b(model_class_b), .contact_inputs(contact_inputs),
    .dc_brake_active(dc_brake_active), .dc_brake_volt(dc_brake_volt),
    .output_shutoff(output_shutoff), .regen_high_duty(regen_high_duty),
    .regen_hc_restart(regen_hc_restart), .regen_duty(regen_duty));
